// [core/ccd_line_transfer_readout.v]
// Host-side timing generator for two-output interline sensor line readout
//
// Added by the designer: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "ccd_readout_consts.vh"

module ccd_line_transfer_readout #(
  parameter ROW_W = 12,
  parameter CNT_W = 16
) (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [31:0] wb_dat_i,
  input  wire [3:0]  wb_sel_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  output reg         vertical_phase_one_o,
  output reg         vertical_phase_two_o,
  output reg         left_storage_a_o,
  output reg         left_storage_b_o,
  output reg         left_barrier_a_o,
  output reg         left_barrier_b_o,
  output reg         right_storage_a_o,
  output reg         right_storage_b_o,
  output reg         right_barrier_a_o,
  output reg         right_barrier_b_o,
  output reg         line_dump_gate_o,
  output reg         reset_gate_o,
  output reg         substrate_o,
  output reg         sample_o,
  output reg         dark_ref_o,
  output reg         image_o,
  output reg         line_start_o,
  output reg         busy_o
);

  localparam ST_IDLE   = 3'd0;
  localparam ST_V1     = 3'd1;
  localparam ST_V2     = 3'd2;
  localparam ST_SETTLE = 3'd3;
  localparam ST_HA     = 3'd4;
  localparam ST_HB     = 3'd5;

  // Header counts are plain integers, trimmed to the counter width here
  localparam integer VPULSE_I = `VPULSE_CYC;
  localparam integer SINGLE_I = `LINE_SINGLE;
  localparam integer DUAL_I   = `LINE_DUAL;
  localparam integer EMPTY_I  = `EMPTY_CELLS;
  localparam integer DARK_I   = `DARK_CELLS;
  localparam integer IMG_S_I  = `IMAGE_SINGLE;
  localparam integer IMG_D_I  = `IMAGE_DUAL;

  localparam [CNT_W-1:0] VPULSE   = VPULSE_I[CNT_W-1:0];
  localparam [CNT_W-1:0] N_SINGLE = SINGLE_I[CNT_W-1:0];
  localparam [CNT_W-1:0] N_DUAL   = DUAL_I[CNT_W-1:0];
  localparam [CNT_W-1:0] N_EMPTY  = EMPTY_I[CNT_W-1:0];
  localparam [CNT_W-1:0] N_DARK   = DARK_I[CNT_W-1:0];
  localparam [CNT_W-1:0] N_IMG_S  = IMG_S_I[CNT_W-1:0];
  localparam [CNT_W-1:0] N_IMG_D  = IMG_D_I[CNT_W-1:0];

  // ==========================================
  // Registers
  reg             dual_r;
  reg             dump_r;
  reg             go_r;
  reg [ROW_W-1:0] rows_r;
  reg [15:0]      settle_r;
  reg [7:0]       div_r;
  reg [ROW_W-1:0] rows_done_r;
  reg             done_r;
  reg [2:0]       state_r;
  reg [CNT_W-1:0] cnt_r;
  reg [CNT_W-1:0] pix_r;
  reg [7:0]       divc_r;
  reg             ha_r;
  reg             vert_r;

  wire            hit  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire            wr   = hit & wb_we_i & wb_sel_i[0];
  // A pixel takes at least two clocks, far below the output amplifier limit
  wire            tick = (divc_r == div_r);
  wire [CNT_W-1:0] line_len = dual_r ? N_DUAL : N_SINGLE;
  wire [CNT_W-1:0] img_end  = N_EMPTY + N_DARK + (dual_r ? N_IMG_D : N_IMG_S);
  // Pixel class of the cell being clocked out now
  wire in_dark  = (pix_r >= N_EMPTY + 16'd1) & (pix_r < N_EMPTY + N_DARK - 16'd1);
  wire in_img   = (pix_r >= N_EMPTY + N_DARK) & (pix_r < img_end);
  wire in_tail  = ~dual_r & (pix_r >= img_end + 16'd1) & (pix_r < N_SINGLE - 16'd1);

  // ==========================================
  // Wishbone slave, ack one cycle after strobe
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      dual_r   <= 1'b0;
      dump_r   <= 1'b0;
      go_r     <= 1'b0;
      rows_r   <= `ROWS_RST;
      settle_r <= `SETTLE_RST;
      div_r    <= `DIV_RST;
    end
    else
    begin
      wb_ack_o <= hit;
      if (hit)
      begin
        case (wb_adr_i)
          `REG_CTRL:   wb_dat_o <= {29'h0, dump_r, dual_r, go_r};
          `REG_STATUS: wb_dat_o <= {15'h0, done_r, 1'b0, busy_o, 2'h0, rows_done_r};
          `REG_ROWS:   wb_dat_o <= {20'h0, rows_r};
          `REG_SETTLE: wb_dat_o <= {16'h0, settle_r};
          `REG_DIV:    wb_dat_o <= {24'h0, div_r};
          default:     wb_dat_o <= 32'h00000000;
        endcase
      end
      // Mode and length frozen while a frame runs, so a line never mixes modes
      if (wr && wb_adr_i == `REG_CTRL && state_r == ST_IDLE)
      begin
        dual_r <= wb_dat_i[`CTRL_DUAL];
        dump_r <= wb_dat_i[`CTRL_DUMP];
      end
      if (wr && wb_adr_i == `REG_CTRL && wb_dat_i[`CTRL_START] && state_r == ST_IDLE)
        go_r <= 1'b1;
      else if (state_r != ST_IDLE)
        go_r <= 1'b0;
      if (wr && wb_adr_i == `REG_ROWS && state_r == ST_IDLE)
        rows_r <= wb_dat_i[ROW_W-1:0];
      if (wr && wb_adr_i == `REG_SETTLE && state_r == ST_IDLE)
        settle_r <= {wb_sel_i[1] ? wb_dat_i[15:8] : settle_r[15:8], wb_dat_i[7:0]};
      if (wr && wb_adr_i == `REG_DIV && state_r == ST_IDLE)
        div_r <= wb_dat_i[7:0];
    end
  end

  wire abort = wr && (wb_adr_i == `REG_CTRL) && wb_dat_i[`CTRL_ABORT];

  // ==========================================
  // Line sequencer
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_r     <= ST_IDLE;
      cnt_r       <= {CNT_W{1'b0}};
      pix_r       <= {CNT_W{1'b0}};
      divc_r      <= 8'h00;
      rows_done_r <= {ROW_W{1'b0}};
      done_r      <= 1'b0;
      ha_r        <= 1'b1;
      vert_r      <= 1'b0;
    end
    else if (abort)
    begin
      state_r <= ST_IDLE;
      ha_r    <= 1'b1;
      vert_r  <= 1'b0;
    end
    else
    begin
      divc_r <= tick ? 8'h00 : divc_r + 8'h01;
      // Done flag: a new frame start clears it, the set from the last row wins
      if (go_r && state_r == ST_IDLE)
        done_r <= 1'b0;
      case (state_r)
        ST_IDLE:
        begin
          ha_r <= 1'b1;
          if (go_r)
          begin
            rows_done_r <= {ROW_W{1'b0}};
            cnt_r       <= {CNT_W{1'b0}};
            vert_r      <= 1'b1;
            state_r     <= ST_V1;
          end
        end
        ST_V1:
        begin
          // Horizontal phases parked a high, b low while vertical moves, except right barriers in single mode (a low, b high)
          ha_r <= 1'b1;
          if (cnt_r == VPULSE - 16'd1)
          begin
            cnt_r   <= {CNT_W{1'b0}};
            state_r <= ST_V2;
          end
          else
            cnt_r <= cnt_r + 16'd1;
        end
        ST_V2:
        begin
          ha_r <= 1'b1;
          if (cnt_r == VPULSE - 16'd1)
          begin
            cnt_r   <= {CNT_W{1'b0}};
            vert_r  <= 1'b0;
            state_r <= ST_SETTLE;
          end
          else
            cnt_r <= cnt_r + 16'd1;
        end
        ST_SETTLE:
        begin
          // Counted from the falling edge of the vertical pulse
          if (cnt_r >= settle_r)
          begin
            cnt_r   <= {CNT_W{1'b0}};
            pix_r   <= {CNT_W{1'b0}};
            state_r <= ST_HA;
          end
          else
            cnt_r <= cnt_r + 16'd1;
        end
        ST_HA:
          if (tick)
          begin
            ha_r    <= 1'b0;
            state_r <= ST_HB;
          end
        ST_HB:
          if (tick)
          begin
            ha_r <= 1'b1;
            if (pix_r == line_len - 16'd1)
            begin
              rows_done_r <= rows_done_r + 1'b1;
              if (rows_done_r + 1'b1 == rows_r)
              begin
                done_r  <= 1'b1;
                state_r <= ST_IDLE;
              end
              else
              begin
                cnt_r   <= {CNT_W{1'b0}};
                vert_r  <= 1'b1;
                state_r <= ST_V1;
              end
            end
            else
            begin
              pix_r   <= pix_r + 16'd1;
              state_r <= ST_HA;
            end
          end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // ==========================================
  // Registered pin drivers; all toggle on one edge to keep barriers aligned
  wire hclk = (state_r == ST_HA) | (state_r == ST_HB);
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      vertical_phase_one_o <= 1'b0;
      vertical_phase_two_o <= 1'b0;
      left_storage_a_o     <= 1'b1;
      left_storage_b_o     <= 1'b0;
      left_barrier_a_o     <= 1'b1;
      left_barrier_b_o     <= 1'b0;
      right_storage_a_o    <= 1'b1;
      right_storage_b_o    <= 1'b0;
      right_barrier_a_o    <= 1'b0;
      right_barrier_b_o    <= 1'b1;
      line_dump_gate_o     <= 1'b0;
      reset_gate_o         <= 1'b0;
      substrate_o          <= 1'b0;
      sample_o             <= 1'b0;
      dark_ref_o           <= 1'b0;
      image_o              <= 1'b0;
      line_start_o         <= 1'b0;
      busy_o               <= 1'b0;
    end
    else
    begin
      vertical_phase_one_o <= vert_r & (state_r == ST_V1);
      vertical_phase_two_o <= vert_r & (state_r == ST_V2);
      left_storage_a_o     <= ha_r;
      left_storage_b_o     <= ~ha_r;
      left_barrier_a_o     <= ha_r;
      left_barrier_b_o     <= ~ha_r;
      right_storage_a_o    <= ha_r;
      right_storage_b_o    <= ~ha_r;
      // Right barriers swapped in single mode, straight in dual mode
      right_barrier_a_o    <= dual_r ? ha_r : ~ha_r;
      right_barrier_b_o    <= dual_r ? ~ha_r : ha_r;
      // Dump gate only spans the vertical transfer, never horizontal readout
      line_dump_gate_o     <= dump_r & vert_r;
      substrate_o          <= 1'b0;
      // Reset gate in the first half pixel, sample strobe in the second
      reset_gate_o         <= (state_r == ST_HA);
      sample_o             <= (state_r == ST_HB) & tick;
      dark_ref_o           <= hclk & (in_dark | in_tail);
      image_o              <= hclk & in_img;
      // Line marker lets downstream buffer and reverse the right half
      line_start_o         <= (state_r == ST_SETTLE) & (cnt_r >= settle_r);
      busy_o               <= (state_r != ST_IDLE) | go_r;
    end
  end

endmodule // ccd_line_transfer_readout

// [core/ccd_readout_consts.vh]
// Constants for the line readout sequencer
// ==========================================
`ifndef CCD_READOUT_CONSTS_VH
`define CCD_READOUT_CONSTS_VH

// ==========================================
// Register map, word offsets in bytes
`define REG_CTRL         8'h00
`define REG_STATUS       8'h04
`define REG_ROWS         8'h08
`define REG_SETTLE       8'h0c
`define REG_DIV          8'h10

// ==========================================
// Control fields
`define CTRL_START       0
`define CTRL_DUAL        1
`define CTRL_DUMP        2
`define CTRL_ABORT       3

// ==========================================
// Reset values
`define ROWS_RST         12'h818
`define SETTLE_RST       16'h000a
`define DIV_RST          8'h00

// ==========================================
// Line geometry
`define EMPTY_CELLS      12
`define DARK_CELLS       28
`define IMAGE_SINGLE     2056
`define IMAGE_DUAL       1028
`define LINE_SINGLE      2124
`define LINE_DUAL        1068
`define SHIELD_ROWS      10
`define PHOTO_ROWS       2062

// ==========================================
// Timing
`define CLK_HZ           10000000
`define VPULSE_NS        1000
`define VPULSE_CYC       ((`VPULSE_NS * (`CLK_HZ / 1000000) + 999) / 1000)

`endif

// [dv/ccd_readout_properties.sv]
// Port assertions for the line readout sequencer
`timescale 1ns/1ps
module ccd_readout_properties (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic vertical_phase_one_o,
  input wire logic vertical_phase_two_o,
  input wire logic left_storage_a_o,
  input wire logic left_storage_b_o,
  input wire logic left_barrier_a_o,
  input wire logic left_barrier_b_o,
  input wire logic right_storage_a_o,
  input wire logic right_storage_b_o,
  input wire logic right_barrier_a_o,
  input wire logic right_barrier_b_o,
  input wire logic line_dump_gate_o,
  input wire logic reset_gate_o,
  input wire logic substrate_o,
  input wire logic image_o
);
  // ==========================================
  // Properties
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_v1; vertical_phase_one_o && !vertical_phase_two_o; endsequence
  sequence s_v2; vertical_phase_two_o && !vertical_phase_one_o; endsequence
  property p_hold;
    (vertical_phase_one_o || vertical_phase_two_o) |-> left_storage_a_o && !left_storage_b_o;
  endproperty
  property p_pair;
    left_storage_b_o == !left_storage_a_o && left_barrier_a_o == left_storage_a_o &&
    left_barrier_b_o == left_storage_b_o && right_storage_a_o == left_storage_a_o &&
    right_storage_b_o == left_storage_b_o;
  endproperty
  property p_rbar; right_barrier_b_o == !right_barrier_a_o; endproperty
  // Settle of 3 under test keeps phase a still for five samples
  property p_settle;
    $fell(vertical_phase_two_o) |-> $stable(left_storage_a_o)[*5] ##[1:40] $fell(left_storage_a_o);
  endproperty
  property p_vorder; $rose(vertical_phase_one_o) |-> s_v1[*8] ##3 s_v2[*8]; endproperty
  property p_dump;
    line_dump_gate_o |-> vertical_phase_one_o || vertical_phase_two_o;
  endproperty
  property p_quiet;
    image_o |-> !vertical_phase_one_o && !vertical_phase_two_o && !line_dump_gate_o && !substrate_o;
  endproperty
  property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o; endproperty
  property p_rgate; reset_gate_o |-> left_storage_a_o && !left_storage_b_o; endproperty
  a_hold: assert property (p_hold) else $error("horizontal not parked");
  a_pair: assert property (p_pair) else $error("phase fan-out wrong");
  a_rbar: assert property (p_rbar) else $error("right barriers not complementary");
  a_settle: assert property (p_settle) else $error("settle delay broken");
  a_vorder: assert property (p_vorder) else $error("vertical pulse order");
  a_dump: assert property (p_dump) else $error("dump outside transfer");
  a_quiet: assert property (p_quiet) else $error("pulse during image");
  a_ack: assert property (p_ack) else $error("bus answer wrong");
  a_rgate: assert property (p_rgate) else $error("reset gate outside phase a");
endmodule // ccd_readout_properties

// [dv/ccd_sensor_model.sv]
// Behavioural sensor model: counts row shifts, dumps and pixels
`timescale 1ns/1ps
module ccd_sensor_model (
  input  wire logic clk_i,
  input  wire logic v_one_i,
  input  wire logic v_two_i,
  input  wire logic ha_i,
  input  wire logic hb_i,
  input  wire logic rba_i,
  input  wire logic dump_i,
  output int        pix_o,
  output int        loaded_o,
  output int        dumped_o,
  output logic      dual_o
);
  logic hb_p = 1'b0;
  logic v1_p = 1'b0;
  logic v2_p = 1'b0;
  logic cut = 1'b0;
  initial
  begin
    pix_o = 0;
    loaded_o = 0;
    dumped_o = 0;
    dual_o = 1'b0;
  end
  // ==========================================
  // Shift tracking
  always @(posedge clk_i)
  begin
    hb_p <= hb_i;
    v1_p <= v_one_i;
    v2_p <= v_two_i;
    if (v_one_i && !v1_p)
      pix_o <= 0;
    else if (hb_i && !hb_p)
    begin
      pix_o <= pix_o + 1;
      dual_o <= (rba_i === ha_i);
    end
    if (dump_i && (v_one_i || v_two_i))
      cut <= 1'b1;
    if (!v_two_i && v2_p)
    begin
      cut <= 1'b0;
      if (cut)
        dumped_o <= dumped_o + 1;
      else
        loaded_o <= loaded_o + 1;
    end
  end
endmodule // ccd_sensor_model

// [dv/testbench.sv]
// Self-checking bench for the line readout sequencer
`timescale 1ns/1ps
module testbench;
  logic        clk_i, rst_i, cyc, stb, we, ack;
  logic [7:0]  adr;
  logic [31:0] wdat, rdat, rd;
  logic [3:0]  sel;
  logic        v1, v2, ha, hb, lba, lbb, rsa, rsb, rba, rbb, dmp, rg, sub, smp, drk, img, ls, busy;
  logic        dual;
  int          fail_count, checked, pix, loaded, dumped, nd, ni, nr, n;
  ccd_line_transfer_readout DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel),
    .wb_dat_o(rdat), .wb_ack_o(ack), .vertical_phase_one_o(v1), .vertical_phase_two_o(v2),
    .left_storage_a_o(ha), .left_storage_b_o(hb), .left_barrier_a_o(lba),
    .left_barrier_b_o(lbb), .right_storage_a_o(rsa), .right_storage_b_o(rsb),
    .right_barrier_a_o(rba), .right_barrier_b_o(rbb), .line_dump_gate_o(dmp),
    .reset_gate_o(rg), .substrate_o(sub), .sample_o(smp), .dark_ref_o(drk),
    .image_o(img), .line_start_o(ls), .busy_o(busy));
  ccd_sensor_model u_model (.clk_i(clk_i), .v_one_i(v1), .v_two_i(v2), .ha_i(ha),
    .hb_i(hb), .rba_i(rba), .dump_i(dmp), .pix_o(pix), .loaded_o(loaded),
    .dumped_o(dumped), .dual_o(dual));
  // ==========================================
  // Clock, counters and tasks
  initial
  begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
  begin
    nd <= ls ? 0 : nd + (smp && drk);
    ni <= ls ? 0 : ni + (smp && img);
    nr <= ls ? 0 : nr + rg;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Waits for ack without assuming a latency; the count limit of 50 ends it if ack never comes
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1 && ++k < 50);
    if (k >= 50)
      fail_count++;
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // ==========================================
  // Tests
  initial
  begin
    {cyc, stb, we, adr, wdat, sel, fail_count, checked} = '0;
    sel = 4'hf;
    rst_i = 1'b1;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check({ha, hb, v1, v2, rba, rbb, busy}, 32'h0000_0042);
    bus(0, 8'h08, 0); check(rd, 32'h0000_0818);
    bus(0, 8'h0c, 0); check(rd, 32'h0000_000a);
    bus(0, 8'h10, 0); check(rd, 32'h0000_0000);
    bus(0, 8'h20, 0); check(rd, 32'h0000_0000);
    for (int m = 0; m < 2; m++)
    begin
      bus(1, 8'h08, 32'h0000_0002);
      bus(1, 8'h0c, 32'h0000_0003);
      bus(1, 8'h00, {29'h0, m[0], m[0], 1'b1});
      check(busy, 32'h1);
      bus(1, 8'h08, 32'h0000_0005);
      bus(0, 8'h08, 0); check(rd, 32'h0000_0002);
      n = 0;
      while (busy !== 1'b0 && n < 20000)
      begin
        @(posedge clk_i);
        n++;
      end
      if (n >= 20000)
        fail_count++;
      check(pix, m ? 1068 : 2124);
      check(nr, m ? 1068 : 2124);
      check(ni, m ? 1028 : 2056);
      check(nd, m ? 26 : 52);
      check(m ? dumped : loaded, 2);
      check(dual, m);
      bus(0, 8'h04, 0); check(rd, 32'h0001_0002);
      $display("mode test %0d finished", m);
    end
    bus(1, 8'h10, 32'h0000_0003);
    bus(0, 8'h10, 0);
    check(rd, 32'h0000_0003);
    bus(1, 8'h00, 32'h0000_0001);
    n = 0;
    while (ls !== 1'b1 && n < 200)
    begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 200)
      fail_count++;
    repeat (50) @(posedge clk_i);
    bus(1, 8'h00, 32'h0000_0008);
    bus(0, 8'h04, 0);
    check(rd, 32'h0000_0000);
    $display("abort test finished");
    complete_run;
  end
  initial
  begin
    repeat (40000) @(posedge clk_i);
    fail_count++;
    complete_run;
  end
endmodule // testbench
bind ccd_line_transfer_readout ccd_readout_properties u_props (.*);
